// ### us_core.sv
/*
 * us_core: decode and datapath of the unsigned subtract instruction with
 * its register file on an AHB-Lite slave port.
 * Assumes the slave is the only one on the bus (hready = hreadyout) and
 * that the master issues single word transfers.
 */
// The placing of the registers and the AHB-Lite register port were left to the implementer.
// Functional notes
// - opcode 01100110 in bits 15:8; bit 7 picks direct or indirect
// - zero-extend 16-bit operand, subtract from accumulator, ignore sxm
// - accumulator signed, operand unsigned: plain subtract, no shift
// - carry cleared on borrow, set otherwise
// - overflow flag updated; saturate when ovm set, else wrap
// - single run 1, 2 shared sa-ram, 1+p, 1+d, 2+d+p cycles
// - repeated run n, n+1, n+p, n+nd, n+1+p+nd cycles
`timescale 1ns/1ps
module us_core (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);
    logic [15:0] ctrl_r;
    logic [15:0] memcfg_r;
    logic [31:0] accumulator_r;
    logic [15:0] pc_r;
    logic carry_r;
    logic overflow_flag_r;
    logic illegal_r;
    logic [us_pkg::US_ADDR_W-1:0] dm_addr_r;
    logic [15:0] dmem [us_pkg::US_DM_DEPTH];
    logic [15:0] aux_r [us_pkg::US_AUX_N];
    logic [us_pkg::US_ADDR_W-1:0] opnd_addr_r;
    logic wr_pend_r;
    logic rd_pend_r;
    logic [7:0] bus_addr_r;
    logic bus_hit_r;
    logic hrdata_sel_ok;
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic hresp_r;
    logic [31:0] rd_mux;
    logic addr_phase;
    logic wr_en;
    logic [7:0] wa;
    logic start;
    logic opc_ok;
    logic [us_pkg::US_ADDR_W-1:0] eff_addr;
    logic busy;
    logic step;
    logic done;
    logic [32:0] diff;
    logic [31:0] result;
    logic borrow;
    logic ovf;
    logic [8:0] reps;
    logic [1:0] code_loc;
    logic [1:0] opnd_loc;

    ////////////////////////////////////////////////////////////////////////
    // bus address phase and write strobes
    assign addr_phase = hsel && htrans[1] && hready;
    assign wr_en = wr_pend_r && bus_hit_r;
    assign wa = bus_addr_r;
    assign hrdata_sel_ok = (haddr[31:8] == 24'h00_0000);

    // capture address phase, one wait state on every read
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            bus_addr_r <= 8'h00;
            bus_hit_r <= 1'b0;
            hreadyout_r <= 1'b1;
        end else begin
            wr_pend_r <= addr_phase && hwrite;
            rd_pend_r <= addr_phase && !hwrite;
            hreadyout_r <= !(addr_phase && !hwrite);
            if (addr_phase) begin
                bus_addr_r <= haddr[7:0];
                bus_hit_r <= hrdata_sel_ok && (hsize == 3'h2);
            end
        end
    end

    // read data from the state as it stands after any earlier write
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hrdata_r <= 32'h0000_0000;
        end else if (rd_pend_r) begin
            hrdata_r <= bus_hit_r ? rd_mux : 32'h0000_0000;
        end
    end

    // every answer is okay
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hresp_r <= 1'b0;
        end else begin
            hresp_r <= 1'b0;
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;

    ////////////////////////////////////////////////////////////////////////
    // register read mux, unmapped reads zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (wa)
            us_pkg::US_OFF_CTRL: rd_mux = {16'h0000, ctrl_r};
            us_pkg::US_OFF_MEMCFG: rd_mux = {16'h0000, memcfg_r};
            us_pkg::US_OFF_ACC: rd_mux = accumulator_r;
            us_pkg::US_OFF_STATUS: begin
                rd_mux[us_pkg::US_ST_C] = carry_r;
                rd_mux[us_pkg::US_ST_OV] = overflow_flag_r;
                rd_mux[us_pkg::US_ST_BUSY] = busy;
                rd_mux[us_pkg::US_ST_ILL] = illegal_r;
            end
            us_pkg::US_OFF_PC: rd_mux = {16'h0000, pc_r};
            us_pkg::US_OFF_DM_ADDR: rd_mux = {25'h000_0000, dm_addr_r};
            us_pkg::US_OFF_DM_DATA: rd_mux = {16'h0000, dmem[dm_addr_r]};
            default: begin
                if (wa >= us_pkg::US_OFF_AUX0 && wa <= us_pkg::US_OFF_AUX7
                    && wa[1:0] == 2'h0) begin
                    rd_mux = {16'h0000, aux_r[wa[4:2]]};
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // mode and memory location registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_r <= us_pkg::US_CTRL_RST;
            memcfg_r <= us_pkg::US_MEMCFG_RST;
        end else if (wr_en && !busy) begin
            if (wa == us_pkg::US_OFF_CTRL) begin
                ctrl_r <= hwdata[15:0];
            end
            if (wa == us_pkg::US_OFF_MEMCFG) begin
                memcfg_r <= hwdata[15:0];
            end
        end
    end

    // data memory window
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dm_addr_r <= '0;
        end else if (wr_en && wa == us_pkg::US_OFF_DM_ADDR) begin
            dm_addr_r <= hwdata[us_pkg::US_ADDR_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (wr_en && wa == us_pkg::US_OFF_DM_DATA) begin
            dmem[dm_addr_r] <= hwdata[15:0];
        end
    end

    // auxiliary address registers
    generate
        for (genvar i = 0; i < us_pkg::US_AUX_N; i++) begin : g_aux
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    aux_r[i] <= 16'h0000;
                end else if (wr_en && !busy
                    && wa == us_pkg::US_OFF_AUX0 + 8'(4 * i)) begin
                    aux_r[i] <= hwdata[15:0];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // decode an instruction word written while idle
    assign opc_ok = (hwdata[15:8] == us_pkg::US_OPC_HI);
    assign start = wr_en && !busy && wa == us_pkg::US_OFF_INSTR && opc_ok;

    // direct uses the low 7 bits, indirect goes through an aux register
    always_comb begin
        if (hwdata[us_pkg::US_OPC_IND]) begin
            eff_addr = aux_r[hwdata[2:0]][us_pkg::US_ADDR_W-1:0];
        end else begin
            eff_addr = hwdata[us_pkg::US_ADDR_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            opnd_addr_r <= '0;
        end else if (start) begin
            opnd_addr_r <= eff_addr;
        end
    end

    // unknown instruction words raise a sticky flag, write one clears
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            illegal_r <= 1'b0;
        end else if (wr_en && !busy && wa == us_pkg::US_OFF_INSTR
            && !opc_ok) begin
            illegal_r <= 1'b1;
        end else if (wr_en && wa == us_pkg::US_OFF_STATUS
            && hwdata[us_pkg::US_ST_ILL]) begin
            illegal_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cycle stretching from operand and code location
    assign reps = 9'(ctrl_r[us_pkg::US_CTRL_RPT_LSB +: us_pkg::US_RPT_W])
        + 9'h001;
    assign code_loc = memcfg_r[us_pkg::US_CFG_CODE_LSB +: 2];
    assign opnd_loc = memcfg_r[us_pkg::US_CFG_OPND_LSB +: 2];

    us_cycle_timer u_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .start(start),
        .reps(reps),
        .code_ext(code_loc == us_pkg::US_LOC_EXT),
        .opnd_ext(opnd_loc == us_pkg::US_LOC_EXT),
        .shared_sa(code_loc == us_pkg::US_LOC_SINGLE_ACCESS_RAM
            && opnd_loc == us_pkg::US_LOC_SINGLE_ACCESS_RAM
            && memcfg_r[us_pkg::US_CFG_SAME]),
        .wait_p(memcfg_r[us_pkg::US_CFG_P_LSB +: us_pkg::US_WAIT_W]),
        .wait_d(memcfg_r[us_pkg::US_CFG_D_LSB +: us_pkg::US_WAIT_W]),
        .busy(busy),
        .step(step),
        .done(done)
    );

    ////////////////////////////////////////////////////////////////////////
    // alu: signed accumulator minus zero-extended operand, no shift
    always_comb begin
        diff = {1'b0, accumulator_r}
            - {17'h0_0000, dmem[opnd_addr_r]};
        borrow = diff[32];
        // negative minus positive landing positive is the only overflow
        ovf = accumulator_r[31] && !diff[31];
        if (ovf && ctrl_r[us_pkg::US_CTRL_OVM]) begin
            result = us_pkg::US_SAT_NEG;
        end else begin
            result = diff[31:0];
        end
    end

    // accumulator: one subtraction per step, software write when idle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            accumulator_r <= us_pkg::US_ACC_RST;
        end else if (step) begin
            accumulator_r <= result;
        end else if (wr_en && !busy && wa == us_pkg::US_OFF_ACC) begin
            accumulator_r <= hwdata;
        end
    end

    // carry follows each step, software may load it when idle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            carry_r <= us_pkg::US_C_RST;
        end else if (step) begin
            carry_r <= !borrow;
        end else if (wr_en && !busy && wa == us_pkg::US_OFF_STATUS) begin
            carry_r <= hwdata[us_pkg::US_ST_C];
        end
    end

    // sticky overflow, set beats a write-one clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            overflow_flag_r <= 1'b0;
        end else if (step && ovf) begin
            overflow_flag_r <= 1'b1;
        end else if (wr_en && wa == us_pkg::US_OFF_STATUS
            && hwdata[us_pkg::US_ST_OV]) begin
            overflow_flag_r <= 1'b0;
        end
    end

    // program counter, one word per completed instruction
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pc_r <= us_pkg::US_PC_RST;
        end else if (done) begin
            pc_r <= pc_r + 16'h0001;
        end else if (wr_en && !busy && wa == us_pkg::US_OFF_PC) begin
            pc_r <= hwdata[15:0];
        end
    end
endmodule // us_core

// ### us_pkg.sv
/*
 * us_pkg: shared constants of the unsigned subtract unit.
 * Assumes a 32-bit AHB-Lite register bus and one core clock.
 */
package us_pkg;
    ////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] US_OFF_CTRL = 8'h00;
    localparam logic [7:0] US_OFF_MEMCFG = 8'h04;
    localparam logic [7:0] US_OFF_INSTR = 8'h08;
    localparam logic [7:0] US_OFF_ACC = 8'h0c;
    localparam logic [7:0] US_OFF_STATUS = 8'h10;
    localparam logic [7:0] US_OFF_PC = 8'h14;
    localparam logic [7:0] US_OFF_DM_ADDR = 8'h18;
    localparam logic [7:0] US_OFF_DM_DATA = 8'h1c;
    localparam logic [7:0] US_OFF_AUX0 = 8'h40;
    localparam logic [7:0] US_OFF_AUX7 = 8'h5c;

    ////////////////////////////////////////////////////////////////////////
    // ctrl fields
    localparam int US_CTRL_SXM = 0;
    localparam int US_CTRL_OVM = 1;
    localparam int US_CTRL_RPT_LSB = 8;
    localparam int US_RPT_W = 8;
    // memcfg fields
    localparam int US_CFG_CODE_LSB = 0;
    localparam int US_CFG_OPND_LSB = 2;
    localparam int US_CFG_SAME = 4;
    localparam int US_CFG_P_LSB = 8;
    localparam int US_CFG_D_LSB = 12;
    localparam int US_WAIT_W = 4;
    // status fields
    localparam int US_ST_C = 0;
    localparam int US_ST_OV = 1;
    localparam int US_ST_BUSY = 2;
    localparam int US_ST_ILL = 3;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [15:0] US_CTRL_RST = 16'h0000;
    localparam logic [15:0] US_MEMCFG_RST = 16'h0000;
    localparam logic [31:0] US_ACC_RST = 32'h0000_0000;
    localparam logic [15:0] US_PC_RST = 16'h0000;
    localparam logic US_C_RST = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // opcode layout and memory locations
    localparam logic [7:0] US_OPC_HI = 8'h66;
    localparam int US_OPC_IND = 7;
    localparam int US_ADDR_W = 7;
    localparam int US_DM_DEPTH = 128;
    localparam int US_AUX_N = 8;
    localparam logic [1:0] US_LOC_ROM = 2'h0;
    localparam logic [1:0] US_LOC_DUAL_ACCESS_RAM = 2'h1;
    localparam logic [1:0] US_LOC_SINGLE_ACCESS_RAM = 2'h2;
    localparam logic [1:0] US_LOC_EXT = 2'h3;
    localparam int US_CNT_W = 13;
    localparam logic [31:0] US_SAT_NEG = 32'h8000_0000;

    // timer states, gray along idle -> run -> idle
    typedef enum logic [1:0] {
        US_IDLE = 2'b00,
        US_RUN = 2'b01
    } us_state_t;
endpackage

// ### us_cycle_timer.sv
/*
 * us_cycle_timer: stretches one instruction to its documented cycle count
 * and marks the cycles in which a subtraction step is taken.
 * Assumes start is a one-cycle pulse, only given while busy is low.
 */
`timescale 1ns/1ps
module us_cycle_timer (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [8:0] reps,
    input wire logic code_ext,
    input wire logic opnd_ext,
    input wire logic shared_sa,
    input wire logic [3:0] wait_p,
    input wire logic [3:0] wait_d,
    output logic busy,
    output logic step,
    output logic done
);
    us_pkg::us_state_t state_r;
    logic [us_pkg::US_CNT_W-1:0] cnt_r;
    logic [us_pkg::US_CNT_W-1:0] total;
    logic [us_pkg::US_CNT_W-1:0] reps_r;
    logic extra;

    ////////////////////////////////////////////////////////////////////////
    // total = n + extra + p(code ext) + n*d(operand ext)
    always_comb begin
        extra = shared_sa | (code_ext & opnd_ext);
        total = us_pkg::US_CNT_W'(reps) + us_pkg::US_CNT_W'(extra)
            + (code_ext ? us_pkg::US_CNT_W'(wait_p) : '0)
            + (opnd_ext ? us_pkg::US_CNT_W'(reps * wait_d) : '0);
    end

    ////////////////////////////////////////////////////////////////////////
    // down counter, one subtraction in each of the last n cycles
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= us_pkg::US_IDLE;
            cnt_r <= '0;
            reps_r <= '0;
        end else begin
            unique case (state_r)
                us_pkg::US_IDLE: begin
                    if (start) begin
                        state_r <= us_pkg::US_RUN;
                        cnt_r <= total;
                        reps_r <= us_pkg::US_CNT_W'(reps);
                    end
                end
                us_pkg::US_RUN: begin
                    cnt_r <= cnt_r - us_pkg::US_CNT_W'(1);
                    if (cnt_r == us_pkg::US_CNT_W'(1)) begin
                        state_r <= us_pkg::US_IDLE;
                    end
                end
            endcase
        end
    end

    assign busy = (state_r == us_pkg::US_RUN);
    assign step = busy && (cnt_r <= reps_r);
    assign done = busy && (cnt_r == us_pkg::US_CNT_W'(1));
endmodule // us_cycle_timer

// ### us_core_checker.sv
/*
 * us_checker: bus-side properties of the unsigned subtract unit.
 * Assumes it is bound to us_core with hready tied to hreadyout.
 */
`timescale 1ns/1ps
module us_checker (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    // accepted transfers
    logic go;
    logic rd_go;
    assign go = hsel && htrans[1] && hready;
    assign rd_go = go && !hwrite;

    // read at a given register offset
    sequence rd_at(logic [7:0] off);
        rd_go && haddr == {24'h0, off};
    endsequence
    // read data phase: one wait, then data
    sequence rd_phase;
        !hreadyout ##1 hreadyout;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("slave gave an error response");
    a_read_wait: assert property (rd_go |=> rd_phase)
        else $error("read data phase not one wait cycle");
    a_write_nowait: assert property (go && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    a_wait_cause: assert property ($fell(hreadyout) |-> $past(rd_go))
        else $error("wait state without a read");
    a_data_hold: assert property (
        !$stable(hrdata) && !$past(rst) |-> $past(hreadyout) == 1'b0)
        else $error("read data changed outside a read");
    a_instr_reads_zero: assert property (
        rd_at(us_pkg::US_OFF_INSTR) |=> rd_phase ##0 hrdata == 32'h0)
        else $error("opcode register did not read zero");
    a_unmapped_zero: assert property (
        rd_go && haddr[31:8] != 24'h0 |=> ##1 hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_pc_word_width: assert property (
        rd_at(us_pkg::US_OFF_PC) |=> ##1 hrdata[31:16] == 16'h0)
        else $error("program counter wider than a word");
    a_status_fields: assert property (
        rd_at(us_pkg::US_OFF_STATUS) |=> ##1 hrdata[31:4] == 28'h0)
        else $error("status upper bits not zero");
endmodule // us_checker

bind us_core us_checker i_us_checker (.sys_clk(sys_clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));

// ### test_unsigned_subtract_instruction.sv
/*
 * test_unsigned_subtract_instruction: self-checking bench of us_core.
 * Assumes the checker is bound in; the bench is the only bus master.
 */
`timescale 1ns/1ps
module test_unsigned_subtract_instruction;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] rdv;
    int error_cnt = 0;
    int comparisons = 0;
    int cyc = 0;
    int took;

    us_core i_us_core (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp));

    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end

    task print_verdict();
        $display("checks %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp,
               input string what);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s got %h want %h", $time, what, seen, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // single word transfer, held until hready is seen high
    task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= a;
        hsize <= 3'b010;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask

    task wr(input logic [7:0] off, input logic [31:0] d);
        bus(1'b1, {24'h0, off}, d);
    endtask

    task rdc(input logic [7:0] off, input logic [31:0] exp, input string s);
        bus(1'b0, {24'h0, off}, 32'h0);
        check(rdv, exp, s);
    endtask

    // start one opcode, poll until idle, note elapsed cycles
    task run(input logic [15:0] op);
        realtime t0;
        int n;
        wr(us_pkg::US_OFF_INSTR, {16'h0, op});
        t0 = $realtime;
        n = 0;
        do begin
            bus(1'b0, {24'h0, us_pkg::US_OFF_STATUS}, 32'h0);
            n++;
        end while (rdv[us_pkg::US_ST_BUSY] !== 1'b0 && n < 200);
        took = int'(($realtime - t0) / 5.0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // reset values and unmapped space
    task test_reset();
        rdc(us_pkg::US_OFF_CTRL, 32'h0, "ctrl reset");
        rdc(us_pkg::US_OFF_MEMCFG, 32'h0, "memcfg reset");
        rdc(us_pkg::US_OFF_ACC, 32'h0, "accumulator reset");
        rdc(us_pkg::US_OFF_STATUS, 32'h0, "status reset");
        rdc(us_pkg::US_OFF_PC, 32'h0, "pc reset");
        rdc(us_pkg::US_OFF_INSTR, 32'h0, "instr reads zero");
        bus(1'b1, 32'h0000_0100, 32'hffff_ffff);
        bus(1'b0, 32'h0000_0100, 32'h0);
        check(rdv, 32'h0, "unmapped read");
        $display("test reset done");
    endtask

    // one direct step with mode bits from ctl; st is {flag of overflow, carry}
    task step(input logic [31:0] a0, input logic [15:0] d,
              input logic [1:0] ctl, input logic [31:0] a1,
              input logic [1:0] st);
        wr(us_pkg::US_OFF_CTRL, {30'h0, ctl});
        wr(us_pkg::US_OFF_DM_ADDR, 32'h5);
        wr(us_pkg::US_OFF_DM_DATA, {16'h0, d});
        wr(us_pkg::US_OFF_ACC, a0);
        wr(us_pkg::US_OFF_STATUS, 32'ha);
        wr(us_pkg::US_OFF_PC, 32'h10);
        run(16'h6605);
        rdc(us_pkg::US_OFF_ACC, a1, "difference");
        rdc(us_pkg::US_OFF_STATUS, {30'h0, st}, "flags");
        rdc(us_pkg::US_OFF_PC, 32'h11, "pc step");
    endtask

    task test_sub();
        step(32'h0000f105, 16'hf003, 2'b01, 32'h00000102, 2'b01);
        step(32'h00000102, 16'hf003, 2'b01, 32'hffff10ff, 2'b00);
        step(32'hfffff000, 16'h0001, 2'b01, 32'hffffefff, 2'b01);
        step(32'h80000000, 16'h0001, 2'b00, 32'h7fffffff, 2'b11);
        step(32'h80000000, 16'h0001, 2'b10, 32'h80000000, 2'b11);
        step(32'h00000000, 16'hffff, 2'b00, 32'hffff0001, 2'b00);
        $display("test subtract done");
    endtask

    // indirect through aux 3, then a foreign opcode
    task test_indirect();
        wr(us_pkg::US_OFF_AUX0 + 8'h0c, 32'h21);
        wr(us_pkg::US_OFF_DM_ADDR, 32'h21);
        wr(us_pkg::US_OFF_DM_DATA, 32'h10);
        wr(us_pkg::US_OFF_ACC, 32'h100);
        run(16'h6683);
        check({31'h0, rdv[us_pkg::US_ST_ILL]}, 32'h0, "no flag");
        rdc(us_pkg::US_OFF_ACC, 32'hf0, "indirect");
        run(16'h6505);
        rdc(us_pkg::US_OFF_ACC, 32'hf0, "foreign opcode");
        rdc(us_pkg::US_OFF_STATUS, 32'h9, "illegal flag");
        $display("test indirect done");
    endtask

    // busy length per memory placement and repeat count
    task test_timing();
        logic [15:0] cfg [6] = '{16'h0000, 16'h001a, 16'h0303,
                                 16'h200d, 16'h230f, 16'h001a};
        int k [6] = '{0, 0, 0, 2, 2, 3};
        int t [6] = '{1, 2, 4, 9, 13, 5};
        logic ok;
        logic [31:0] acc_exp;
        for (int i = 0; i < 6; i++) begin
            wr(us_pkg::US_OFF_CTRL, 32'(k[i]) << 8);
            wr(us_pkg::US_OFF_MEMCFG, {16'h0, cfg[i]});
            wr(us_pkg::US_OFF_DM_ADDR, 32'h5);
            wr(us_pkg::US_OFF_DM_DATA, 32'h3);
            wr(us_pkg::US_OFF_ACC, 32'h64);
            wr(us_pkg::US_OFF_PC, 32'h0);
            run(16'h6605);
            // status poll sees busy drop on a four-cycle grid
            ok = took == (t[i] + 5) / 4 * 4;
            check({31'h0, ok}, 32'h1, "busy length");
            acc_exp = 32'h64 - 32'(3 * (k[i] + 1));
            rdc(us_pkg::US_OFF_ACC, acc_exp, "repeats");
            rdc(us_pkg::US_OFF_PC, 32'h1, "pc once");
        end
        $display("test timing done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        test_reset();
        test_sub();
        test_indirect();
        test_timing();
        print_verdict();
    end
endmodule // test_unsigned_subtract_instruction
